/* File: pkg/hrs_params.svh */
// Constants of the home return sequencer: offsets, fields, codes, tag and home position
// Function
// - Second methods on default pattern raise 0821 error
// - Absolute high-speed return positions to zero
// - Deviation counter untouched; clear is separate
// - Data set zeroes controller position, not amplifier's
// - Data set stores amplifier position as offset
// - Offset persists; displayed position subtracts it
// - Incremental data set zeroes amplifier position
// - Method, direction, ramps, speeds are configured
// - Busy rises at start, falls at finish
// - Done holds until next operation starts
// - Start and status bits placed by axis number
// - Start accepted with either limit active
// - Limit hit in travel direction reverses travel, except with HRS_M_LIM2, where it stops travel
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH

// Register byte addresses
`define HRS_A_CTRL      12'h000
`define HRS_A_STATUS    12'h004
`define HRS_A_CONFIG    12'h008
`define HRS_A_ACCEL     12'h00C
`define HRS_A_DECEL     12'h010
`define HRS_A_TARGET    12'h014
`define HRS_A_CREEP     12'h018
`define HRS_A_ERRCODE   12'h01C
`define HRS_A_CURPOS    12'h020
`define HRS_A_AMPPOS    12'h024
`define HRS_A_IRQ_STAT  12'h028
`define HRS_A_IRQ_MASK  12'h02C
`define HRS_A_OFS_BASE  12'h330
`define HRS_A_OFS_LAST  12'h33F

// Control register fields (start bit sits at the axis number)
`define HRS_CTRL_DEVCLR 8
`define HRS_CTRL_OTHER  9
`define HRS_CTRL_ERRCLR 10
// Status register: busy at axis, done at axis+8, error at axis+16
`define HRS_ST_DONE_OFS 8
`define HRS_ST_ERR_OFS  16
// Config register fields
`define HRS_CFG_METH_HI 3
`define HRS_CFG_DIR     4
`define HRS_CFG_ZERO    5
// Interrupt bits
`define HRS_IRQ_DONE    0
`define HRS_IRQ_ERR     1

// Amplifier input assignment codes
`define HRS_PA_IN2      32'h0081_8181
`define HRS_PA_IN3      32'h0082_8282
`define HRS_PA_IN6      32'h0021_2121
`define HRS_PB_IN2      32'h0000_0000
`define HRS_PB_IN6      32'h0001_0101
`define HRS_PB_IN7      32'h0002_0202
`define HRS_ERR_LATCH   16'h0821

// Offset store tag marks valid content (arbitrary value)
`define HRS_OFS_TAG     32'h5AC3_0001
`define HRS_HOME_POS    32'h0000_0000

`endif

/* File: pkg/hrs_pkg.sv */
// Types of the home return sequencer
package hrs_pkg;

  // Gray coded along idle-check-search-creep-stop-store-finish
  typedef enum logic [2:0] {
    HRS_IDLE   = 3'h0,
    HRS_CHECK  = 3'h1,
    HRS_SEARCH = 3'h3,
    HRS_CREEP  = 3'h2,
    HRS_STOP   = 3'h6,
    HRS_STORE  = 3'h7,
    HRS_FINISH = 3'h5,
    HRS_RELOAD = 3'h4
  } hrs_state_t;

  typedef enum logic [3:0] {
    HRS_M_DOG1    = 4'h0,
    HRS_M_DOG2    = 4'h1,
    HRS_M_LIM1    = 4'h2,
    HRS_M_LIM2    = 4'h3,
    HRS_M_ZPHASE  = 4'h4,
    HRS_M_DATASET = 4'h5,
    HRS_M_HSABS   = 4'h6
  } hrs_method_t;

endpackage

/* File: verilog/hrs_offset_mem.sv */
// Offset store: four words, no reset so content outlives a restart
`timescale 1ns/1ps
`default_nettype none
module hrs_offset_mem (
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port, data registered
  input  wire logic [1:0]  raddr,
  output var  logic [31:0] rdata_r
);

  logic [31:0] mem [0:3];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule // hrs_offset_mem
`default_nettype wire

/* File: verilog/hrs_sequencer.sv */
// Home return sequencer for one axis with register port
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hrs_params.svh"
module hrs_sequencer
  import hrs_pkg::*;
#(
  parameter int AXIS_NUM = 0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata_r,
  output var  logic        irq_r,
  // Amplifier inputs
  input  wire logic        forward_overtravel,
  input  wire logic        reverse_overtravel,
  input  wire logic        near_home_switch,
  input  wire logic        home_ref_edge,
  input  wire logic        amp_motion_done,
  input  wire logic [31:0] amp_pos,
  input  wire logic [31:0] amp_input_six_cfg,
  // Amplifier commands
  output var  logic        drive_fwd_r,
  output var  logic        drive_rev_r,
  output var  logic [31:0] drive_speed_r,
  output var  logic [15:0] accel_ms_r,
  output var  logic [15:0] decel_ms_r,
  output var  logic        pos_move_r,
  output var  logic [31:0] pos_target_r,
  output var  logic        amp_zero_r,
  output var  logic        dev_clear_r
);

  // Methods that need the changed input assignment
  function automatic logic needs_pat_b(input hrs_method_t m);
    needs_pat_b = (m == HRS_M_DOG2) || (m == HRS_M_LIM2);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  hrs_state_t  state_r, state_nxt;
  hrs_method_t meth_r;
  logic        dir_fwd_r, dir_nxt;
  logic        zero_cfg_r;
  logic [31:0] target_r, creep_r;
  logic        busy_r, done_r, err_r;
  logic [15:0] err_code_r;
  logic [1:0]  irq_stat_r, irq_mask_r;
  logic [31:0] offset_r, cur_pos_r;
  logic [31:0] ofs_w1_r;
  logic [1:0]  st_idx_r;
  logic        reload_pend_r;
  logic        dog_prev_r, ref_prev_r;
  logic [31:0] mem_rdata;
  logic        dir_nxt_q;
  logic        cfg_dir_r;
  logic [1:0]  rd_idx_r;
  logic        tag_ok, tag_seen_r;
  logic        reload_wait_r, reload_w2_r;
  logic [31:0] word0_q;

  // Bus decode
  wire wr_ctrl   = wr && hit(addr, `HRS_A_CTRL);
  wire wr_cfg    = wr && hit(addr, `HRS_A_CONFIG);
  wire start_req = wr_ctrl && wdata[AXIS_NUM];
  // Start while busy or still reloading is ignored, never left pending
  wire accept    = start_req && !busy_r && (state_r != HRS_RELOAD);
  wire other_op  = wr_ctrl && wdata[`HRS_CTRL_OTHER];
  wire err_clr   = wr_ctrl && wdata[`HRS_CTRL_ERRCLR];
  wire ofs_rd    = (addr >= `HRS_A_OFS_BASE) && (addr <= `HRS_A_OFS_LAST);
  wire [1:0] ofs_word = addr[3:2];

  // Edge and reference events
  wire dog_rise  = near_home_switch && !dog_prev_r;
  wire zref_rise = home_ref_edge && !ref_prev_r;
  wire lim_ref   = (meth_r == HRS_M_LIM2) &&
                   (dir_fwd_r ? forward_overtravel : reverse_overtravel);
  wire reverse   = (meth_r != HRS_M_LIM2) &&
                   (dir_fwd_r ? forward_overtravel
                              : reverse_overtravel);
  wire pat_a     = (amp_input_six_cfg == `HRS_PA_IN6);
  wire pat_err   = (state_r == HRS_CHECK) && needs_pat_b(meth_r) &&
                   pat_a;
  wire moving    = (state_r == HRS_SEARCH) || (state_r == HRS_CREEP);

  // Value stored into the offset words
  wire [31:0] store_val = zero_cfg_r ? 32'h0000_0000 : amp_pos;
  wire        mem_we    = (state_r == HRS_STORE);
  wire [31:0] mem_wdata = (st_idx_r == 2'h0) ? store_val :
                          (st_idx_r == 2'h1) ? {32{store_val[31]}} :
                          (st_idx_r == 2'h2) ? 32'h0000_0000 :
                          `HRS_OFS_TAG;

  // Next state
  always_comb begin
    state_nxt = state_r;
    dir_nxt   = dir_fwd_r;
    case (state_r)
      HRS_RELOAD: state_nxt = HRS_IDLE;
      HRS_IDLE: begin
        if (accept) begin
          state_nxt = HRS_CHECK;
        end
      end
      HRS_CHECK: begin
        if (pat_err) begin
          state_nxt = HRS_FINISH;
        end else if (meth_r == HRS_M_DATASET) begin
          state_nxt = HRS_STORE;
        end else if (meth_r == HRS_M_HSABS) begin
          state_nxt = HRS_STOP;
        end else if (meth_r == HRS_M_ZPHASE) begin
          state_nxt = HRS_CREEP;
        end else begin
          state_nxt = HRS_SEARCH;
        end
      end
      HRS_SEARCH: begin
        if (reverse) begin
          dir_nxt = !dir_fwd_r;
        end
        if (lim_ref || (meth_r == HRS_M_DOG2 && dog_rise)) begin
          state_nxt = HRS_STOP;
        end else if (meth_r == HRS_M_DOG1 && dog_rise) begin
          state_nxt = HRS_CREEP;
        end else if (meth_r == HRS_M_LIM1 && reverse) begin
          state_nxt = HRS_CREEP;
        end
      end
      HRS_CREEP: begin
        if (reverse) begin
          dir_nxt = !dir_fwd_r;
        end
        if (zref_rise) begin
          state_nxt = HRS_STOP;
        end
      end
      HRS_STOP: begin
        if (amp_motion_done) begin
          state_nxt = HRS_FINISH;
        end
      end
      HRS_STORE: begin
        if (st_idx_r == 2'h3) begin
          state_nxt = HRS_FINISH;
        end
      end
      HRS_FINISH: state_nxt = HRS_IDLE;
      default:    state_nxt = HRS_IDLE;
    endcase
  end

  wire moving_nxt = (state_nxt == HRS_SEARCH) || (state_nxt == HRS_CREEP);
  // Direction that applies next cycle, start takes the configured one
  assign dir_nxt_q = accept ? cfg_dir_r : dir_nxt;

  // Sequencer state; reset lands in reload to recover the offset
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= HRS_RELOAD;
      dir_fwd_r  <= 1'b0;
      st_idx_r   <= 2'h0;
      dog_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dir_fwd_r  <= dir_nxt_q;
      st_idx_r   <= mem_we ? st_idx_r + 2'h1 : 2'h0;
      dog_prev_r <= near_home_switch;
      ref_prev_r <= home_ref_edge;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      meth_r     <= HRS_M_DOG1;
      cfg_dir_r  <= 1'b0;
      zero_cfg_r <= 1'b0;
      accel_ms_r <= 16'h0000;
      decel_ms_r <= 16'h0000;
      target_r   <= 32'h0000_0000;
      creep_r    <= 32'h0000_0000;
      irq_mask_r <= 2'h0;
    end else if (wr && !busy_r) begin
      if (wr_cfg) begin
        meth_r     <= hrs_method_t'(wdata[`HRS_CFG_METH_HI:0]);
        cfg_dir_r  <= wdata[`HRS_CFG_DIR];
        zero_cfg_r <= wdata[`HRS_CFG_ZERO];
      end
      if (hit(addr, `HRS_A_ACCEL))    accel_ms_r <= wdata[15:0];
      if (hit(addr, `HRS_A_DECEL))    decel_ms_r <= wdata[15:0];
      if (hit(addr, `HRS_A_TARGET))   target_r   <= wdata;
      if (hit(addr, `HRS_A_CREEP))    creep_r    <= wdata;
      if (hit(addr, `HRS_A_IRQ_MASK)) irq_mask_r <= wdata[1:0];
    end
  end

  // Busy, done and error flags
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
      err_code_r <= 16'h0000;
    end else begin
      if (accept) begin
        busy_r <= 1'b1;
      end else if (state_r == HRS_FINISH) begin
        busy_r <= 1'b0;
      end
      if (state_r == HRS_FINISH && !err_r) begin
        done_r <= 1'b1;
      end else if (accept || other_op) begin
        done_r <= 1'b0;
      end
      if (pat_err) begin
        err_r      <= 1'b1;
        err_code_r <= `HRS_ERR_LATCH;
      end else if (err_clr) begin
        err_r      <= 1'b0;
        err_code_r <= 16'h0000;
      end
    end
  end

  // Drive commands; deviation counter only cleared on its own request
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_fwd_r   <= 1'b0;
      drive_rev_r   <= 1'b0;
      drive_speed_r <= 32'h0000_0000;
      pos_move_r    <= 1'b0;
      pos_target_r  <= `HRS_HOME_POS;
      amp_zero_r    <= 1'b0;
      dev_clear_r   <= 1'b0;
    end else begin
      drive_fwd_r   <= moving_nxt && dir_nxt_q;
      drive_rev_r   <= moving_nxt && !dir_nxt_q;
      drive_speed_r <= (state_nxt == HRS_SEARCH) ? target_r : creep_r;
      pos_move_r    <= (state_r == HRS_CHECK) && !pat_err &&
                       (meth_r == HRS_M_HSABS);
      pos_target_r  <= `HRS_HOME_POS;
      amp_zero_r    <= (state_r == HRS_CHECK) && zero_cfg_r &&
                       (meth_r == HRS_M_DATASET);
      dev_clear_r   <= wr_ctrl && wdata[`HRS_CTRL_DEVCLR];
    end
  end

  // Offset shadow and displayed position
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_pend_r <= 1'b0;
      offset_r      <= 32'h0000_0000;
      ofs_w1_r      <= 32'h0000_0000;
      cur_pos_r     <= 32'h0000_0000;
    end else begin
      reload_pend_r <= (state_r == HRS_RELOAD);
      if (reload_pend_r) begin
        offset_r <= 32'h0000_0000; // Word 0 fetched below
      end
      if (mem_we && st_idx_r == 2'h0) begin
        offset_r <= store_val;
      end else if (mem_we && st_idx_r == 2'h1) begin
        ofs_w1_r <= mem_wdata;
      end else if (tag_ok) begin
        offset_r <= word0_q;
      end
      cur_pos_r <= amp_pos - offset_r;
    end
  end

  // Reload walks word 3 (tag) then word 0; untagged store means zero
  // Word 0 leaves the registered read one cycle after its address
  assign word0_q = mem_rdata;
  assign tag_ok  = tag_seen_r && reload_w2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_idx_r      <= 2'h3;
      tag_seen_r    <= 1'b0;
      reload_wait_r <= 1'b0;
      reload_w2_r   <= 1'b0;
    end else begin
      reload_wait_r <= reload_pend_r;
      reload_w2_r   <= reload_wait_r;
      if (state_r == HRS_RELOAD) begin
        rd_idx_r <= 2'h3;
      end else if (reload_pend_r) begin
        tag_seen_r <= (mem_rdata == `HRS_OFS_TAG);
        rd_idx_r   <= 2'h0;
      end
    end
  end

  hrs_offset_mem u_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (st_idx_r),
    .wdata   (mem_wdata),
    .raddr   (rd_idx_r),
    .rdata_r (mem_rdata)
  );

  // Interrupt status: set wins over write-one-clear
  wire [1:0] irq_set = {pat_err, (state_r == HRS_FINISH) && !err_r};
  wire [1:0] irq_clr = (wr && hit(addr, `HRS_A_IRQ_STAT)) ? wdata[1:0]
                                                          : 2'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_r      <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // Read mux; status bits placed by axis number
  logic [31:0] status_w, rd_mux;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[AXIS_NUM] = busy_r;
    status_w[AXIS_NUM + `HRS_ST_DONE_OFS] = done_r;
    status_w[AXIS_NUM + `HRS_ST_ERR_OFS]  = err_r;
  end
  assign rd_mux =
    ofs_rd ? ((ofs_word == 2'h0) ? offset_r :
              (ofs_word == 2'h1) ? ofs_w1_r :
              (ofs_word == 2'h3) ? `HRS_OFS_TAG : 32'h0000_0000) :
    hit(addr, `HRS_A_STATUS)   ? status_w :
    hit(addr, `HRS_A_CONFIG)   ? {26'h0, zero_cfg_r, cfg_dir_r, meth_r} :
    hit(addr, `HRS_A_ACCEL)    ? {16'h0, accel_ms_r} :
    hit(addr, `HRS_A_DECEL)    ? {16'h0, decel_ms_r} :
    hit(addr, `HRS_A_TARGET)   ? target_r :
    hit(addr, `HRS_A_CREEP)    ? creep_r :
    hit(addr, `HRS_A_ERRCODE)  ? {16'h0, err_code_r} :
    hit(addr, `HRS_A_CURPOS)   ? cur_pos_r :
    hit(addr, `HRS_A_AMPPOS)   ? amp_pos :
    hit(addr, `HRS_A_IRQ_STAT) ? {30'h0, irq_stat_r} :
    hit(addr, `HRS_A_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h0000_0000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_on_start: assert property (accept |=> busy_r && !done_r)
    else $error("busy not raised on start");
  a_done_clr_start: assert property (done_r && accept |=> !done_r)
    else $error("done kept across new start");
  a_done_finish: assert property ((state_r == HRS_FINISH) && !err_r
    |=> done_r && !busy_r)
    else $error("finish did not set done");
  a_done_holds: assert property (done_r && !accept && !other_op
    |=> done_r)
    else $error("done dropped early");
  a_latch_error: assert property (pat_err |=> err_r &&
    err_code_r == `HRS_ERR_LATCH && !drive_fwd_r && !drive_rev_r)
    else $error("pattern error not flagged");
  a_hs_zero: assert property ($rose(pos_move_r) |->
    pos_target_r == 32'h0 && $past(meth_r) == HRS_M_HSABS)
    else $error("high-speed return not to zero");
  a_dev_untouched: assert property (dev_clear_r |->
    $past(wr_ctrl && wdata[`HRS_CTRL_DEVCLR]))
    else $error("deviation clear without request");
  a_store_offset: assert property (mem_we && st_idx_r == 2'h0
    |=> offset_r == $past(store_val))
    else $error("offset not captured");
  a_auto_reverse: assert property (moving && drive_fwd_r && reverse
    && state_nxt != HRS_STOP |=> drive_rev_r)
    else $error("no reversal at limit");
  a_start_limit: assert property (accept |=> state_r == HRS_CHECK ##1
    state_r != HRS_IDLE)
    else $error("start refused");

  c_start: cover property (accept);
  c_error: cover property (pat_err);
  c_reverse: cover property (moving && reverse);
  c_done: cover property (state_r == HRS_FINISH && !err_r);

endmodule // hrs_sequencer
`default_nettype wire

/* File: bench/hrs_amp_model.sv */
// Servo amplifier stand-in: travel, limits, markers, input pattern
`timescale 1ns/1ps
`default_nettype none
`include "hrs_params.svh"
module hrs_amp_model #(
  parameter int LIM     = 300,
  parameter int NEAR_LO = 40,
  parameter int NEAR_HI = 60
) (
  // Clock
  input  wire logic        clk,
  // Bench controls
  input  wire logic        preset,
  input  wire logic [31:0] preset_val,
  input  wire logic        pattern_b,
  input  wire logic        slow,
  // Commands from the sequencer
  input  wire logic        drive_fwd,
  input  wire logic        drive_rev,
  input  wire logic        pos_move,
  input  wire logic [31:0] pos_target,
  input  wire logic        amp_zero,
  // Feedback to the sequencer
  output var  logic        forward_overtravel,
  output var  logic        reverse_overtravel,
  output var  logic        near_home_switch,
  output var  logic        home_ref_edge,
  output var  logic        amp_motion_done,
  output var  logic [31:0] amp_pos,
  output var  logic [31:0] amp_input_six_cfg
);
  int   pos    = 0;
  int   tgt    = 0;
  int   tick   = 0;
  int   step;
  logic moving = 1'b0;
  logic ref_q  = 1'b0;

  // Sixth input code tells the loaded pattern; levels stay high active
  assign amp_input_six_cfg  = pattern_b ? `HRS_PB_IN6 : `HRS_PA_IN6;
  assign amp_pos            = 32'(pos);
  assign forward_overtravel = pos >= LIM;
  assign reverse_overtravel = pos <= -LIM;
  assign near_home_switch   = pos >= NEAR_LO && pos <= NEAR_HI;
  assign home_ref_edge      = ref_q;
  assign step               = drive_fwd ? 1 : -1;
  // Busy while a move is pending, so a fresh command never reads as done
  assign amp_motion_done = !moving && !pos_move && !drive_fwd && !drive_rev;

  // Slow mode steps once in four cycles; marker every 16 counts
  always @(posedge clk) begin
    ref_q <= 1'b0;
    tick <= slow ? (tick + 1) % 4 : 0;
    if (preset) begin
      pos <= int'(preset_val);
      moving <= 1'b0;
    end else if (amp_zero) begin
      pos <= 0;
    end else if (pos_move) begin
      tgt <= int'(pos_target);
      moving <= 1'b1;
    end else if (tick == 0 && moving) begin
      pos <= pos + ((tgt > pos) ? 1 : (tgt < pos) ? -1 : 0);
      moving <= pos != tgt;
    end else if (tick == 0 && (drive_fwd ^ drive_rev)) begin
      pos <= pos + step;
      ref_q <= ((pos + step) % 16) == 0;
    end
  end
endmodule // hrs_amp_model
`default_nettype wire

/* File: bench/home_return_sequencer_bench.sv */
// Self-checking bench of the home return sequencer with amplifier model
`timescale 1ns/1ps
`default_nettype none
`include "hrs_params.svh"
module home_return_sequencer_bench;
  localparam int AX = 2;
  // Clock, reset, register port
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [11:0] addr  = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata_r;
  logic        irq_r;
  // Amplifier side
  logic        fwd_ot, rev_ot, near_sw, ref_edge, mdone;
  logic        dfwd, drev, pmove, azero, dclr;
  logic [31:0] amp_pos, six_cfg, spd, ptgt;
  logic [15:0] acc, dec;
  logic        preset = 1'b0;
  logic        pat_b  = 1'b0;
  logic        slow   = 1'b0;
  logic [31:0] preset_val = 32'h0;
  // Bench model state
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n_dclr = 0;
  int          lim_run = 0;
  int          meth = 0;
  logic [31:0] rv, exp_ofs;
  logic [31:0] seed = 32'h1A;
  logic [31:0] cfg [4];

  hrs_sequencer #(.AXIS_NUM(AX)) hrs_sequencer_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .irq_r(irq_r), .forward_overtravel(fwd_ot),
    .reverse_overtravel(rev_ot), .near_home_switch(near_sw),
    .home_ref_edge(ref_edge), .amp_motion_done(mdone), .amp_pos(amp_pos),
    .amp_input_six_cfg(six_cfg), .drive_fwd_r(dfwd), .drive_rev_r(drev),
    .drive_speed_r(spd), .accel_ms_r(acc), .decel_ms_r(dec),
    .pos_move_r(pmove), .pos_target_r(ptgt), .amp_zero_r(azero),
    .dev_clear_r(dclr));

  hrs_amp_model hrs_amp_model_inst (
    .clk(clk), .preset(preset), .preset_val(preset_val), .pattern_b(pat_b),
    .slow(slow), .drive_fwd(dfwd), .drive_rev(drev), .pos_move(pmove),
    .pos_target(ptgt), .amp_zero(azero), .forward_overtravel(fwd_ot),
    .reverse_overtravel(rev_ot), .near_home_switch(near_sw),
    .home_ref_edge(ref_edge), .amp_motion_done(mdone), .amp_pos(amp_pos),
    .amp_input_six_cfg(six_cfg));

  // Clock
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    $display("CHECK FAILED %0t: %s", $time, msg);
    miscompares++;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail($sformatf("%s got %h exp %h", msg, got, exp));
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Watchdogs; a drive held into its own limit means no reversal
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (dclr) n_dclr <= n_dclr + 1;
    lim_run <= (((dfwd && fwd_ot) || (drev && rev_ot)) && meth != 3) ?
               lim_run + 1 : 0;
    if (lim_run == 8) fail("no reversal at limit");
    if (cycles == 60000) begin
      fail("timeout");
      give_verdict();
    end
  end

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [11:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata_r;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 2000; i++) begin
      rreg(`HRS_A_STATUS);
      if (rv[AX] === 1'b0) return;
    end
    fail("busy stuck");
  endtask

  // One home return; the model predicts flags, offset and position
  task automatic run(input int m, input logic dir, pb, zb,
                     input logic [31:0] p0);
    logic err;
    err = (m == 1 || m == 3) && !pb;
    meth = m;
    @(posedge clk);
    preset <= 1'b1;
    preset_val <= p0;
    pat_b <= pb;
    @(posedge clk);
    preset <= 1'b0;
    wreg(`HRS_A_CONFIG, {26'h0, zb, dir, m[3:0]});
    wreg(`HRS_A_IRQ_STAT, 32'h3);
    wreg(`HRS_A_CTRL, 32'h1 << AX);
    if (m < 5 && !err) begin
      rreg(`HRS_A_STATUS);
      chk({30'h0, rv[AX], rv[AX+8]}, 32'h2, "busy at start");
      chk(spd, (m == 4) ? cfg[3] : cfg[2], "drive speed");
    end
    wait_idle();
    rreg(`HRS_A_STATUS);
    chk({30'h0, rv[AX+8], rv[AX+16]}, {30'h0, !err, err}, "flags");
    rreg(`HRS_A_IRQ_STAT);
    chk(rv, {30'h0, err, !err}, "irq status");
    chk({31'h0, irq_r}, 32'h1, "irq level");
    if (err) begin
      rreg(`HRS_A_ERRCODE);
      chk(rv, {16'h0, `HRS_ERR_LATCH}, "error code");
      wreg(`HRS_A_CTRL, 32'h400);
    end
    if (m == 6) chk(amp_pos, `HRS_HOME_POS, "abs return");
    if (m == 5) begin
      exp_ofs = zb ? 32'h0 : p0;
      chk(amp_pos, exp_ofs, "amplifier position");
      rreg(`HRS_A_OFS_BASE);
      chk(rv, exp_ofs, "stored offset");
      rreg(`HRS_A_CURPOS);
      chk(rv, 32'h0, "controller position");
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(`HRS_A_STATUS);
    chk(rv, 32'h0, "status after reset");
    rreg(12'h100);
    chk(rv, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      rv = rnd();
      cfg[i] = {16'h0, rv[15:0]};
      wreg(`HRS_A_ACCEL + 12'(4 * i), cfg[i]);
      rreg(`HRS_A_ACCEL + 12'(4 * i));
      chk(rv, cfg[i], "config readback");
    end
    wreg(`HRS_A_IRQ_MASK, 32'h3);
    // Every method under both input patterns
    for (int pb = 0; pb < 2; pb++) begin
      for (int m = 0; m < 7; m++) begin
        rv = rnd();
        slow <= rv[1];
        run(m, rv[0], pb[0], pb[0], (rnd() % 400) - 200);
      end
    end
    chk({acc, dec}, {cfg[0][15:0], cfg[1][15:0]}, "ramp times");
    // Start against an active limit in either direction, then a data set and another operation
    run(0, 1'b1, 1'b1, 1'b0, 32'd320);
    run(0, 1'b0, 1'b1, 1'b0, -32'd320);
    run(5, 1'b0, 1'b1, 1'b0, 32'd137);
    wreg(`HRS_A_CTRL, 32'h200);
    rreg(`HRS_A_STATUS);
    chk({31'h0, rv[AX+8]}, 32'h0, "done cleared by other start");
    // Interrupt masked, unmasked, then cleared
    wreg(`HRS_A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_r}, 32'h0, "masked irq");
    wreg(`HRS_A_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_r}, 32'h1, "unmasked irq");
    wreg(`HRS_A_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_r}, 32'h0, "cleared irq");
    // Reset in mid motion: offset must survive the restart
    wreg(`HRS_A_CONFIG, 32'h10);
    wreg(`HRS_A_CTRL, 32'h1 << AX);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(`HRS_A_STATUS);
    chk(rv, 32'h0, "status after second reset");
    rreg(`HRS_A_OFS_BASE);
    chk(rv, exp_ofs, "offset kept");
    rreg(`HRS_A_CURPOS);
    chk(rv, amp_pos - exp_ofs, "displayed position");
    chk(32'(n_dclr), 32'h0, "no automatic deviation clear");
    wreg(`HRS_A_CTRL, 32'h100);
    repeat (3) @(posedge clk);
    chk(32'(n_dclr), 32'h1, "requested deviation clear");
    give_verdict();
  end
endmodule // home_return_sequencer_bench
`default_nettype wire
